// [rtl/counter_array_control_mode.sv]
// Control and mode registers of the counter array with its 16-bit counter
//
// Notes on behaviour
// (RULE_01) Overflow flag set on wrap, software clears
// (RULE_02) Overflow flag with enable raises interrupt
// (RULE_03) Run bit zero stops, one counts
// (RULE_04) Module event flags set by hardware only; the code also lets a software write of one set them
// (RULE_05) Enabled module event flag raises interrupt
// (RULE_06) Idle-suspend bit pauses counting in idle
// (RULE_07) Watchdog enable resets to one, module two
// (RULE_08) Lock bit blocks disabling watchdog until reset
// (RULE_09) Three-bit code selects counter timebase
// (RULE_10) Code 011 counts count-pin falling edges
// (RULE_11) Codes 101/110 count slow clocks over eight
// (RULE_12) Watchdog on freezes other mode bits
// (RULE_13) Mode bit four reads zero, ignores writes
// (RULE_14) Control register supports single-bit writes
// (RULE_15) Watchdog on forces the counter running
// (RULE_16) Low-byte overflow on high match resets
// (RULE_17) Writing watchdog event flag forces reset
// (RULE_18) Counter increments one per tick, wraps
`timescale 1ns/1ps
`default_nettype none
module counter_array_control_mode (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_bit_mask,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_clk,
    input wire logic rtc_clk,
    input wire logic [5:0] module_event,
    input wire logic [5:0] module_irq_enable,
    input wire logic [7:0] watchdog_compare_high,
    output logic [7:0] counter_low_byte,
    output logic [7:0] counter_high_byte,
    output logic counter_tick,
    output logic watchdog_function,
    output logic irq_request,
    output logic watchdog_reset
);
    timebase_if tb_link ();

    logic counter_overflow_flag_q; // Sticky overflow flag
    logic counter_run_control_q; // Software run bit
    logic [5:0] module_event_flags_q; // Sticky module flags
    logic idle_suspend_q; // Pause in processor idle
    logic watchdog_enable_q; // Watchdog enable
    logic watchdog_lock_q; // Watchdog lock
    logic [2:0] timebase_select_q; // Timebase code
    logic overflow_irq_enable_q; // Overflow interrupt mask
    logic [15:0] count_q; // The 16-bit counter
    logic [7:0] rdata_q; // Registered read data
    logic wr_ctl;
    logic wr_mode;
    logic [7:0] ctl_now;
    logic [7:0] ctl_next;
    logic [7:0] mode_next;
    logic advance;
    logic wrap;
    logic low_wrap;

    // Merge a write with the current value using the per-bit mask
    function automatic logic [7:0] merge_bits(input logic [7:0] cur, input logic [7:0] val,
                                              input logic [7:0] mask);
        merge_bits = (cur & ~mask) | (val & mask);
    endfunction

    assign wr_ctl = sfr_wr && (sfr_addr == counter_array_pkg::ADDR_ARRAY_CONTROL);
    assign wr_mode = sfr_wr && (sfr_addr == counter_array_pkg::ADDR_ARRAY_MODE);

    assign ctl_now = {counter_overflow_flag_q, counter_run_control_q, module_event_flags_q};
    // Bit set/clear touches only masked bits; byte writes use a full mask
    assign ctl_next = merge_bits(ctl_now, sfr_wdata, sfr_bit_mask); // see (RULE_14)
    assign mode_next = merge_bits({idle_suspend_q, watchdog_enable_q, watchdog_lock_q, 1'b0,
                                   timebase_select_q, overflow_irq_enable_q},
                                  sfr_wdata, sfr_bit_mask);

    assign tb_link.select = timebase_select_q;

    // Timebase generator
    counter_timebase u_timebase (
        .clk_sys(clk_sys),
        .reset(reset),
        .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input),
        .ext_osc_clk(ext_osc_clk),
        .rtc_clk(rtc_clk),
        .tb(tb_link.gen)
    );

    // Counting runs on run bit or watchdog, paused when idle-suspended
    assign advance = tb_link.tick && (counter_run_control_q || watchdog_enable_q) && // see (RULE_03) (RULE_15)
                     !(idle_suspend_q && cpu_idle); // see (RULE_06)
    assign wrap = advance && (count_q == 16'hFFFF); // see (RULE_01)
    assign low_wrap = advance && (count_q[7:0] == 8'hFF);

    // Counter register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_q <= 16'h0000;
        end else if (advance) begin
            count_q <= count_q + 16'h0001; // see (RULE_18)
        end
    end

    // Control register: hardware sets win over software clears
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            counter_overflow_flag_q <= counter_array_pkg::RESET_ARRAY_CONTROL[7];
            counter_run_control_q <= counter_array_pkg::RESET_ARRAY_CONTROL[6];
            module_event_flags_q <= counter_array_pkg::RESET_ARRAY_CONTROL[5:0];
        end else begin
            if (wr_ctl) begin
                counter_overflow_flag_q <= ctl_next[counter_array_pkg::CTL_OVERFLOW_POS] | wrap;
                counter_run_control_q <= ctl_next[counter_array_pkg::CTL_RUN_POS];
                module_event_flags_q <= ctl_next[5:0] | module_event; // see (RULE_04)
            end else begin
                counter_overflow_flag_q <= counter_overflow_flag_q | wrap; // see (RULE_01)
                module_event_flags_q <= module_event_flags_q | module_event; // see (RULE_04)
            end
        end
    end

    // Mode register with watchdog freeze and lock
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            idle_suspend_q <= counter_array_pkg::RESET_ARRAY_MODE[7];
            watchdog_enable_q <= counter_array_pkg::RESET_ARRAY_MODE[6]; // see (RULE_07)
            watchdog_lock_q <= counter_array_pkg::RESET_ARRAY_MODE[5];
            timebase_select_q <= counter_array_pkg::RESET_ARRAY_MODE[3:1];
            overflow_irq_enable_q <= counter_array_pkg::RESET_ARRAY_MODE[0];
        end else if (wr_mode) begin
            if (!watchdog_enable_q) begin
                // Watchdog off: every bit but bit four writable; lock also turns watchdog on
                idle_suspend_q <= mode_next[counter_array_pkg::MODE_IDLE_POS];
                watchdog_lock_q <= mode_next[counter_array_pkg::MODE_WD_LOCK_POS];
                watchdog_enable_q <= mode_next[counter_array_pkg::MODE_WD_ENABLE_POS] |
                                     mode_next[counter_array_pkg::MODE_WD_LOCK_POS];
                timebase_select_q <= mode_next[3:1];
                overflow_irq_enable_q <= mode_next[counter_array_pkg::MODE_IRQ_EN_POS];
            end else begin
                // Watchdog on: only the enable may change, and only unlocked; see (RULE_12)
                if (!watchdog_lock_q) begin
                    watchdog_enable_q <= mode_next[counter_array_pkg::MODE_WD_ENABLE_POS]; // see (RULE_08)
                end
            end
        end
    end

    // Read data; run bit reads as stored, unused mode bit reads zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd && sfr_addr == counter_array_pkg::ADDR_ARRAY_CONTROL) begin
            rdata_q <= ctl_now;
        end else if (sfr_rd && sfr_addr == counter_array_pkg::ADDR_ARRAY_MODE) begin
            rdata_q <= {idle_suspend_q, watchdog_enable_q, watchdog_lock_q, 1'b0, // see (RULE_13)
                        timebase_select_q, overflow_irq_enable_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Interrupt request and watchdog reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_request <= 1'b0;
            watchdog_reset <= 1'b0;
        end else begin
            irq_request <= (counter_overflow_flag_q && overflow_irq_enable_q) || // see (RULE_02)
                           |(module_event_flags_q & module_irq_enable); // see (RULE_05)
            watchdog_reset <= watchdog_enable_q &&
                ((low_wrap && watchdog_compare_high == count_q[15:8]) || // see (RULE_16)
                 (wr_ctl && sfr_bit_mask[counter_array_pkg::WATCHDOG_MODULE] &&
                  sfr_wdata[counter_array_pkg::WATCHDOG_MODULE])); // see (RULE_17)
        end
    end

    assign sfr_rdata = rdata_q;
    assign counter_low_byte = count_q[7:0];
    assign counter_high_byte = count_q[15:8];
    assign counter_tick = advance;
    assign watchdog_function = watchdog_enable_q; // see (RULE_07)
endmodule // counter_array_control_mode
`default_nettype wire

// [rtl/counter_array_pkg.sv]
// Package: register map, field positions, reset values and timebase codes for the counter array
package counter_array_pkg;
    // Register addresses on the special-function bus
    localparam logic [7:0] ADDR_ARRAY_CONTROL = 8'hD8;
    localparam logic [7:0] ADDR_ARRAY_MODE = 8'hD9;
    // Reset values
    localparam logic [7:0] RESET_ARRAY_CONTROL = 8'h00;
    localparam logic [7:0] RESET_ARRAY_MODE = 8'h40;
    // Control register fields
    localparam int CTL_OVERFLOW_POS = 7;
    localparam int CTL_RUN_POS = 6;
    // Mode register fields
    localparam int MODE_IDLE_POS = 7;
    localparam int MODE_WD_ENABLE_POS = 6;
    localparam int MODE_WD_LOCK_POS = 5;
    localparam int MODE_UNUSED_POS = 4;
    localparam int MODE_SEL_LSB = 1;
    localparam int MODE_IRQ_EN_POS = 0;
    // Module number used by the watchdog function
    localparam int WATCHDOG_MODULE = 2;
    // Timebase divider counts
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV8_LAST = 4'h7;
    // Timebase source codes
    typedef enum logic [2:0] {
        SRC_SYS_DIV12 = 3'h0,
        SRC_SYS_DIV4 = 3'h1,
        SRC_TIMER0 = 3'h2,
        SRC_EXT_FALL = 3'h3,
        SRC_SYS = 3'h4,
        SRC_EXT_OSC_DIV8 = 3'h5,
        SRC_RTC_DIV8 = 3'h6,
        SRC_RESERVED = 3'h7
    } timebase_sel_t;
endpackage : counter_array_pkg

// [rtl/timebase_if.sv]
// Interface: selected timebase code and the tick it produces
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
    logic [2:0] select; // Timebase code from mode register
    logic tick; // One-cycle count tick
    modport gen (input select, output tick);
    modport user (output select, input tick);
endinterface : timebase_if
`default_nettype wire

// [rtl/counter_timebase.sv]
// Timebase generator: dividers, synchronisers and edge detectors for the counter clock
`timescale 1ns/1ps
`default_nettype none
module counter_timebase (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_clk,
    input wire logic rtc_clk,
    timebase_if.gen tb
);
    logic [3:0] div_q; // Prescaler for divide-by-12 and divide-by-4
    logic [2:0] ext_sync_q; // Count pin sync pair plus history
    logic [2:0] osc_sync_q; // Oscillator sync pair plus history
    logic [2:0] rtc_sync_q; // Real-time clock sync pair plus history
    logic [2:0] osc_div_q; // Counts oscillator rising edges
    logic [2:0] rtc_div_q; // Counts real-time clock rising edges
    logic osc_rise;
    logic rtc_rise;
    logic ext_fall;

    // Three-stage shift: stages 0 and 1 synchronise, stage 2 keeps history
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ext_sync_q <= 3'h7;
            osc_sync_q <= 3'h0;
            rtc_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_count_input};
            osc_sync_q <= {osc_sync_q[1:0], ext_osc_clk};
            rtc_sync_q <= {rtc_sync_q[1:0], rtc_clk};
        end
    end

    // Edges look only at the second and third stages
    assign ext_fall = ext_sync_q[2] & ~ext_sync_q[1]; // see (RULE_10)
    assign osc_rise = ~osc_sync_q[2] & osc_sync_q[1];
    assign rtc_rise = ~rtc_sync_q[2] & rtc_sync_q[1];

    // System clock prescaler, wraps at the limit of the chosen divider
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= 4'h0;
        end else if ((tb.select == 3'h0 && div_q >= counter_array_pkg::DIV12_LAST) ||
                     (tb.select == 3'h1 && div_q >= counter_array_pkg::DIV4_LAST)) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // Divide-by-eight of the synchronised slow clocks
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            osc_div_q <= 3'h0;
            rtc_div_q <= 3'h0;
        end else begin
            if (osc_rise) begin
                osc_div_q <= osc_div_q + 3'h1; // see (RULE_11)
            end
            if (rtc_rise) begin
                rtc_div_q <= rtc_div_q + 3'h1; // see (RULE_11)
            end
        end
    end

    // Source multiplexer
    always_comb begin
        case (tb.select)
            counter_array_pkg::SRC_SYS_DIV12: tb.tick = (div_q == counter_array_pkg::DIV12_LAST); // see (RULE_09)
            counter_array_pkg::SRC_SYS_DIV4: tb.tick = (div_q == counter_array_pkg::DIV4_LAST);
            counter_array_pkg::SRC_TIMER0: tb.tick = timer0_overflow;
            counter_array_pkg::SRC_EXT_FALL: tb.tick = ext_fall;
            counter_array_pkg::SRC_SYS: tb.tick = 1'b1;
            counter_array_pkg::SRC_EXT_OSC_DIV8: tb.tick = osc_rise &&
                ({1'b0, osc_div_q} == counter_array_pkg::DIV8_LAST);
            counter_array_pkg::SRC_RTC_DIV8: tb.tick = rtc_rise &&
                ({1'b0, rtc_div_q} == counter_array_pkg::DIV8_LAST);
            default: tb.tick = 1'b0; // Reserved code never counts
        endcase
    end
endmodule // counter_timebase
`default_nettype wire

// [tb/counter_array_sva.sv]
// Checker: port-level properties of the counter array control block
`timescale 1ns/1ps
`default_nettype none
module counter_array_sva (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_bit_mask,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic [5:0] module_event,
    input wire logic [5:0] module_irq_enable,
    input wire logic [7:0] watchdog_compare_high,
    input wire logic [7:0] counter_low_byte,
    input wire logic [7:0] counter_high_byte,
    input wire logic counter_tick,
    input wire logic watchdog_function,
    input wire logic irq_request,
    input wire logic watchdog_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Control write that forces the watchdog module flag
    wire logic force_wr = sfr_wr && sfr_addr == 8'hD8 && sfr_bit_mask[2] && sfr_wdata[2];
    // Tick that overflows the low byte
    wire logic wrap_hit = counter_tick && counter_low_byte == 8'hFF;
    // Enabled event, then a quiet cycle with the enable held
    sequence event_armed;
        |(module_event & module_irq_enable) ##1 ($stable(module_irq_enable) && !sfr_wr);
    endsequence
    AST_RD_IDLE: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not idle");
    AST_UNUSED_ZERO: assert property (sfr_rd && sfr_addr == 8'hD9 |=> !sfr_rdata[4])
        else $error("mode bit four not zero");
    AST_WD_AT_RESET: assert property ($fell(reset) |-> watchdog_function)
        else $error("watchdog off after reset");
    AST_STEP: assert property (counter_tick |=> {counter_high_byte, counter_low_byte} ==
        $past({counter_high_byte, counter_low_byte}) + 16'h1) else $error("counter step wrong");
    AST_HOLD: assert property (!counter_tick |=> $stable({counter_high_byte, counter_low_byte}))
        else $error("counter moved without tick");
    AST_WD_WRAP: assert property (wrap_hit && watchdog_function &&
        counter_high_byte == watchdog_compare_high |=> watchdog_reset) else $error("no wrap reset");
    AST_WD_FORCE: assert property (force_wr && watchdog_function |=> watchdog_reset)
        else $error("no forced reset");
    AST_WD_CAUSE: assert property (watchdog_reset |-> $past(force_wr || wrap_hit))
        else $error("reset without cause");
    AST_WD_FROZEN: assert property ($changed(watchdog_function) |->
        $past(sfr_wr && sfr_addr == 8'hD9)) else $error("enable changed without write");
    AST_EVT_IRQ: assert property (event_armed |=> irq_request)
        else $error("event interrupt missing");
endmodule // counter_array_sva
bind counter_array_control_mode counter_array_sva u_sva (.clk_sys(clk_sys), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_bit_mask(sfr_bit_mask),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .module_event(module_event),
    .module_irq_enable(module_irq_enable), .watchdog_compare_high(watchdog_compare_high),
    .counter_low_byte(counter_low_byte), .counter_high_byte(counter_high_byte),
    .counter_tick(counter_tick), .watchdog_function(watchdog_function),
    .irq_request(irq_request), .watchdog_reset(watchdog_reset));
`default_nettype wire

// [tb/testbench.sv]
// Testbench: registers, timebases, events and watchdog of the counter array
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_mask = 8'h00;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, cpu_idle = 1'b0, timer0_overflow = 1'b0;
    logic external_count_input = 1'b1, ext_osc_clk = 1'b0, rtc_clk = 1'b0, rd_q = 1'b0;
    logic [5:0] module_event = 6'h00, module_irq_enable = 6'h00;
    logic [7:0] watchdog_compare_high = 8'h00, sfr_rdata, counter_low_byte, counter_high_byte;
    logic counter_tick, watchdog_function, irq_request, watchdog_reset;
    int errors = 0, comparisons = 0, seed = 32'h627A, ticks, want, i, j, k;
    logic [7:0] exp_q[$];
    // Mode byte per step and ticks expected in the window
    logic [7:0] tbl_mode[10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h88, 8'h08};
    int tbl_want[10] = '{4, 12, 0, 6, 48, 1, 1, 0, 0, 48};
    initial forever #12.5 clk_sys = ~clk_sys;
    counter_array_control_mode u_dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_bit_mask(sfr_bit_mask), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input), .ext_osc_clk(ext_osc_clk),
        .rtc_clk(rtc_clk), .module_event(module_event), .module_irq_enable(module_irq_enable),
        .watchdog_compare_high(watchdog_compare_high), .counter_low_byte(counter_low_byte),
        .counter_high_byte(counter_high_byte), .counter_tick(counter_tick),
        .watchdog_function(watchdog_function), .irq_request(irq_request),
        .watchdog_reset(watchdog_reset));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One bus cycle: write when w, else read with d as the noted expectation
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_bit_mask = m;
        sfr_wr = w;
        sfr_rd = !w;
        if (!w) exp_q.push_back(d);
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask
    // Counts ticks over the first m of n cycles while step k drives its source
    task automatic tally(input int n, input int m);
        ticks = 0;
        for (i = 0; i < n; i++) begin
            @(negedge clk_sys);
            if (counter_tick && i < m) ticks++;
            timer0_overflow = k == 2 && i < 48 && ($random(seed) & 3) == 0;
            want += timer0_overflow;
            external_count_input = k != 3 || i >= 48 || !i[2];
            ext_osc_clk = k == 5 && i < 48 && i[1];
            rtc_clk = k == 6 && i < 48 && i[1];
        end
    endtask
    // Read data lands one cycle after its strobe
    always @(posedge clk_sys) rd_q <= sfr_rd;
    always @(negedge clk_sys) if (rd_q) check(sfr_rdata, exp_q.pop_front());
    initial begin
        #2250000;
        errors++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        bus(0, 8'hD8, 8'h00, 8'h00);
        bus(0, 8'hD9, 8'h40, 8'h00);
        bus(0, 8'hD0, 8'h00, 8'h00);
        bus(1, 8'hD9, 8'h4F, 8'hFF);
        bus(0, 8'hD9, 8'h40, 8'h00);
        bus(1, 8'hD9, 8'h00, 8'hFF);
        check(watchdog_function, 0);
        bus(1, 8'hD9, 8'h9F, 8'hFF);
        bus(0, 8'hD9, 8'h8F, 8'h00);
        bus(1, 8'hD8, 8'h40, 8'h40);
        bus(0, 8'hD8, 8'h40, 8'h00);
        // Every timebase code, then idle with and without suspend
        for (k = 0; k < 10; k++) begin
            bus(1, 8'hD9, tbl_mode[k], 8'hFF);
            bus(0, 8'hD9, tbl_mode[k], 8'h00);
            cpu_idle = tbl_mode[k][7] || k == 9;
            want = tbl_want[k];
            tally(56, k inside {2, 3, 5, 6} ? 56 : 48);
            check(ticks, want);
        end
        cpu_idle = 1'b0;
        bus(1, 8'hD8, 8'h00, 8'h40);
        tally(20, 20);
        check(ticks, 0);
        // Full wrap at the system clock with overflow interrupt on
        bus(1, 8'hD9, 8'h09, 8'hFF);
        bus(1, 8'hD8, 8'h40, 8'h40);
        i = 0;
        while (!(counter_tick && {counter_high_byte, counter_low_byte} == 16'hFFFF) && i < 70000) begin
            @(negedge clk_sys);
            i++;
        end
        bus(1, 8'hD8, 8'h00, 8'h40);
        bus(0, 8'hD8, 8'h80, 8'h00);
        check(irq_request, 1);
        bus(1, 8'hD9, 8'h08, 8'hFF);
        bus(0, 8'hD9, 8'h08, 8'h00);
        check(irq_request, 0);
        bus(1, 8'hD8, 8'h00, 8'h80);
        bus(0, 8'hD8, 8'h00, 8'h00);
        // Event on a random module, masked then enabled, then set beats clear
        j = ($random(seed) & 255) % 6;
        @(negedge clk_sys);
        module_event[j] = 1'b1;
        @(negedge clk_sys);
        module_event = 6'h00;
        bus(0, 8'hD8, 8'h01 << j, 8'h00);
        check(irq_request, 0);
        module_irq_enable[j] = 1'b1;
        bus(0, 8'hD8, 8'h01 << j, 8'h00);
        check(irq_request, 1);
        fork
            bus(1, 8'hD8, 8'h00, 8'h01 << j);
            begin
                @(negedge clk_sys);
                module_event[j] = 1'b1;
                @(negedge clk_sys);
                module_event[j] = 1'b0;
            end
        join
        bus(0, 8'hD8, 8'h01 << j, 8'h00);
        bus(1, 8'hD8, 8'h00, 8'h01 << j);
        bus(0, 8'hD8, 8'h00, 8'h00);
        module_irq_enable = 6'h00;
        // Watchdog on: forced run, forced reset, compare-match reset, lock
        bus(1, 8'hD9, 8'h40, 8'hFF);
        k = 10;
        tally(48, 48);
        check(ticks, 4);
        bus(1, 8'hD8, 8'h04, 8'h04);
        check(watchdog_reset, 1);
        watchdog_compare_high = counter_high_byte;
        i = 0;
        while (watchdog_reset !== 1'b1 && i < 4000) begin
            @(negedge clk_sys);
            i++;
        end
        check(i < 4000, 1);
        bus(1, 8'hD9, 8'h00, 8'hFF);
        bus(1, 8'hD9, 8'h20, 8'hFF);
        bus(1, 8'hD9, 8'h00, 8'hFF);
        bus(0, 8'hD9, 8'h60, 8'h00);
        check(watchdog_function, 1);
        reset = 1'b1;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        bus(0, 8'hD9, 8'h40, 8'h00);
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
